/* rtl/core_sfr_pkg.sv */
// Shared constants and types for the core special-function register bank
package core_sfr_pkg;

  // Register indexes; the bus byte address is four times the index
  localparam logic [9:0] IDX_TIMER_ZERO_VALUE  = 10'h001;
  localparam logic [9:0] IDX_PROGRAM_COUNTER_LOW = 10'h002;
  localparam logic [9:0] IDX_STATUS_FLAGS      = 10'h003;
  localparam logic [9:0] IDX_INDIRECT_POINTER  = 10'h004;
  localparam logic [9:0] IDX_FIRST_PORT_DATA   = 10'h005;
  localparam logic [9:0] IDX_SECOND_PORT_DATA  = 10'h006;
  localparam logic [9:0] IDX_POWER_CONTROL     = 10'h008;
  localparam logic [9:0] IDX_PORT_B_WAKE_CONTROL = 10'h009;
  localparam logic [9:0] IDX_PC_HIGH_BUFFER    = 10'h00a;

  // Status field positions
  localparam int STATUS_CARRY      = 0;
  localparam int STATUS_HALF_CARRY = 1;
  localparam int STATUS_ZERO       = 2;
  localparam int STATUS_POWER_DOWN = 3;
  localparam int STATUS_WDT_EXPIRY = 4;
  localparam int STATUS_BANK_LO    = 6;
  localparam int STATUS_BANK_HI    = 7;

  // Power control field positions
  localparam int POWER_CONTROL_COMPARATOR   = 2;
  localparam int POWER_CONTROL_LVR          = 3;
  localparam int POWER_CONTROL_LVD          = 5;
  localparam int POWER_CONTROL_WATCHDOG     = 7;

  // High buffer field positions
  localparam int PCHB_BOOST_STOP   = 6;
  localparam int PCHB_SINK_ENABLE  = 7;

  // Reset values
  localparam logic [7:0]  STATUS_RESET        = 8'h18;
  localparam logic [7:0]  POWER_CONTROL_RESET = 8'h88;
  localparam logic [5:0]  PORT_B_WAKE_RESET   = 6'h3f;
  localparam logic [2:0]  PC_HIGH_BUF_RESET   = 3'h0;
  localparam logic [10:0] PROGRAM_COUNTER_RESET = 11'h000;
  localparam logic [7:0]  INDIRECT_PTR_RESET  = 8'h00;

  typedef enum logic [2:0] {
    instr_step,
    instr_short_jump,
    instr_short_call,
    instr_long_jump,
    instr_long_call,
    instr_sleep,
    instr_clear_watchdog
  } instr_kind_t;

  typedef enum logic [1:0] {
    alu_none,
    alu_add,
    alu_sub,
    alu_logic
  } alu_op_t;

endpackage : core_sfr_pkg

/* rtl/timer_zero_if.sv */
// Link between the register bank and the timer-zero counter
`timescale 1ns/1ps
`default_nettype none
interface timer_zero_if;
  logic       load;        // One-cycle load strobe
  logic [7:0] load_value;  // Byte to load
  logic [7:0] count;       // Live count

  modport bank  (output load, output load_value, input count);
  modport timer (input load, input load_value, output count);
endinterface : timer_zero_if
`default_nettype wire

/* rtl/timer_zero_counter.sv */
// Timer-zero counter with clock-source choice
`timescale 1ns/1ps
`default_nettype none
module timer_zero_counter
  import core_sfr_pkg::*;
(
  input  wire logic clk_sys,                 // System clock
  input  wire logic sys_rst,                 // Async reset, high
  input  wire logic instruction_clock,       // One-cycle tick per instruction
  input  wire logic external_count_input,    // Count pin, asynchronous
  input  wire logic low_osc_clock,           // Low-frequency oscillator, asynchronous
  input  wire logic timer_zero_mode_select,  // 0: instruction clock, 1: pin or low osc
  input  wire logic low_osc_select,          // Configuration word: low osc instead of pin
  timer_zero_if.timer link                   // Load and count to the bank
);

  logic [2:0] ext_sync;
  logic [2:0] osc_sync;
  logic       count_tick;

  // Two stages before use; the third stage only feeds edge detection
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ext_sync <= 3'h0;
      osc_sync <= 3'h0;
    end
    else
    begin
      ext_sync <= {ext_sync[1:0], external_count_input};
      osc_sync <= {osc_sync[1:0], low_osc_clock};
    end
  end

  always_comb
  begin
    if (!timer_zero_mode_select)
      count_tick = instruction_clock;
    else if (low_osc_select)
      count_tick = osc_sync[1] & ~osc_sync[2];
    else
      count_tick = ext_sync[1] & ~ext_sync[2];
  end

  // A load wins over a tick in the same cycle
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      link.count <= 8'h00;
    else if (link.load)
      link.count <= link.load_value;
    else if (count_tick)
      link.count <= link.count + 8'h01;
  end

endmodule : timer_zero_counter
`default_nettype wire

/* rtl/core_special_register_bank.sv */
// Core special-function register bank with APB access
// Functional notes
// - Reading the timer-zero register returns the live running count.
// - Writing the timer-zero register replaces the count at once.
// - Timer zero counts instruction clock, count pin or low oscillator by selection.
// - PC low byte of an 11-bit PC; PC steps by one unless loaded.
// - PC bits 10:8 come from the high buffer on low-byte writes and short calls; other loads and steps set them too.
// - Short jump loads PC[8:0] from instruction, PC[10:9] from buffer bits 2:1.
// - Short call loads PC[7:0], PC[10:8] from buffer, pushes PC+1.
// - Long jump or call loads all 11 bits; long call pushes PC+1.
// - Carry is one on add carry or subtract without borrow.
// - Half carry is one on carry from, or no borrow into, bit 3.
// - Zero flag set when a logical result is zero, else cleared.
// - Power-down flag one after reset or watchdog clear, zero after sleep.
// - Watchdog expiry flag one after reset, clear or sleep; zero on timeout.
// - Two-bit bank select picks data bank 0 to 3.
// - Pointer bits 6:0 select one of 128 registers; bit 7 general.
// - Port read gives pin for inputs; outputs give pin or latch by option.
// - Port writes land in the output data latch.
// - Second port bits 7 and 6 are general read/write storage.
// - Power control holds watchdog, LVD, LVR, comparator enables; others general.
// - Port-B wake control gives six wake enables, all reset to one.
// - Writing one to the boost stop bit ends crystal speed-up.
// - Constant sink enable is high buffer bit 7, reset zero.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module core_special_register_bank
  import core_sfr_pkg::*;
(
  input  wire logic        clk_sys,                    // System clock, 50 MHz
  input  wire logic        sys_rst,                    // Async reset, high
  // APB slave
  input  wire logic        psel,                       // Select
  input  wire logic        penable,                    // Access phase
  input  wire logic        pwrite,                     // Write when high
  input  wire logic [11:0] paddr,                      // Byte address
  input  wire logic [31:0] pwdata,                     // Write data
  output logic      [31:0] prdata,                     // Read data
  output logic             pready,                     // Ready
  output logic             pslverr,                    // Error on unmapped address
  // Instruction sequencing from the core
  input  wire logic        instr_valid,                // One instruction retires
  input  wire instr_kind_t instr_kind,                 // Kind of retiring instruction
  input  wire logic [10:0] instr_target,               // Address field of the instruction
  input  wire logic        alu_valid,                  // ALU result strobe
  input  wire alu_op_t     alu_op,                     // ALU operation class
  input  wire logic [7:0]  alu_a,                      // First operand
  input  wire logic [7:0]  alu_b,                      // Second operand
  input  wire logic [7:0]  alu_logic_result,           // Result of a logical operation
  input  wire logic        watchdog_timeout,           // Watchdog expired, one-cycle pulse
  // Pins and options
  input  wire logic [7:0]  first_port_pins,            // First port pin levels, async
  input  wire logic [5:0]  second_port_pins,           // Second port pin levels, async
  input  wire logic [7:0]  first_port_is_input,        // 1: pin is an input
  input  wire logic [5:0]  second_port_is_input,       // 1: pin is an input
  input  wire logic        port_readback_option,       // 1: outputs read the latch
  input  wire logic        timer_zero_mode_select,     // Timer source select
  input  wire logic        timer_zero_low_osc_select,  // Configuration word source choice
  input  wire logic        instruction_clock,          // Instruction tick
  input  wire logic        external_count_input,       // Timer count pin
  input  wire logic        low_osc_clock,              // Low oscillator
  // Outputs
  output logic      [10:0] program_counter,            // Current PC
  output logic             stack_push,                 // Push strobe
  output logic      [10:0] stack_push_addr,            // Return address pushed
  output logic      [7:0]  status_flags,               // Status register
  output logic      [7:0]  indirect_pointer,           // Indirect pointer
  output logic      [7:0]  first_port_latch,           // First port output latch
  output logic      [7:0]  second_port_latch,          // Second port latch, bits 7:6 general
  output logic      [7:0]  power_control,              // Power control register
  output logic      [5:0]  port_b_wake_enable,         // Port-B wake enables
  output logic      [2:0]  program_counter_high_buffer, // PC high buffer bits
  output logic             crystal_boost_stop,         // Speed-up stopped, sticky
  output logic             constant_sink_enable        // Constant sink on
);

  timer_zero_if tz ();

  logic [7:0]  first_pins_meta;
  logic [7:0]  first_pins_sync;
  logic [5:0]  second_pins_meta;
  logic [5:0]  second_pins_sync;
  logic        access;
  logic        wr_en;
  logic [9:0]  reg_index;
  logic        addr_aligned;
  logic [7:0]  wbyte;
  logic [7:0]  read_byte;
  logic        read_hit;
  logic [10:0] pc_plus_one;

  assign access       = psel & penable & pready;
  assign wr_en        = access & pwrite & addr_aligned;
  assign reg_index    = paddr[11:2];
  assign addr_aligned = (paddr[1:0] == 2'b00);
  assign wbyte        = pwdata[7:0];
  assign pc_plus_one  = program_counter + 11'h001;

  function automatic logic [7:0] port_read(input logic [7:0] pins,
                                           input logic [7:0] latch,
                                           input logic [7:0] is_input,
                                           input logic       option);
    logic [7:0] res;
    res = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      if (is_input[i] || !option)
        res[i] = pins[i];
      else
        res[i] = latch[i];
    end
    return res;
  endfunction : port_read

  function automatic logic half_carry(input alu_op_t op,
                                      input logic [7:0] a,
                                      input logic [7:0] b);
    logic [4:0] nib;
    nib = 5'h00;
    if (op == alu_add)
    begin
      nib = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      return nib[4];
    end
    return a[3:0] >= b[3:0];
  endfunction : half_carry

  function automatic logic full_carry(input alu_op_t op,
                                      input logic [7:0] a,
                                      input logic [7:0] b);
    logic [8:0] sum;
    sum = 9'h000;
    if (op == alu_add)
    begin
      sum = {1'b0, a} + {1'b0, b};
      return sum[8];
    end
    return a >= b;
  endfunction : full_carry

  timer_zero_counter u_timer_zero (
    .clk_sys                (clk_sys),
    .sys_rst                (sys_rst),
    .instruction_clock      (instruction_clock),
    .external_count_input   (external_count_input),
    .low_osc_clock          (low_osc_clock),
    .timer_zero_mode_select (timer_zero_mode_select),
    .low_osc_select         (timer_zero_low_osc_select),
    .link                   (tz.timer)
  );

  // Pins are asynchronous; reads only see the second stage
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      first_pins_meta  <= 8'h00;
      first_pins_sync  <= 8'h00;
      second_pins_meta <= 6'h00;
      second_pins_sync <= 6'h00;
    end
    else
    begin
      first_pins_meta  <= first_port_pins;
      first_pins_sync  <= first_pins_meta;
      second_pins_meta <= second_port_pins;
      second_pins_sync <= second_pins_meta;
    end
  end

  // One wait state: pready rises the cycle after the access phase starts
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      pready <= 1'b0;
    else
      pready <= psel & penable & ~pready;
  end

  always_comb
  begin
    read_byte = 8'h00;
    read_hit  = 1'b1;
    if (reg_index == IDX_TIMER_ZERO_VALUE)
      read_byte = tz.count;
    else if (reg_index == IDX_PROGRAM_COUNTER_LOW)
      read_byte = program_counter[7:0];
    else if (reg_index == IDX_STATUS_FLAGS)
      read_byte = status_flags;
    else if (reg_index == IDX_INDIRECT_POINTER)
      read_byte = indirect_pointer;
    else if (reg_index == IDX_FIRST_PORT_DATA)
      read_byte = port_read(first_pins_sync, first_port_latch,
                            first_port_is_input, port_readback_option);
    else if (reg_index == IDX_SECOND_PORT_DATA)
      read_byte = port_read({second_port_latch[7:6], second_pins_sync},
                            second_port_latch, {2'b00, second_port_is_input},
                            port_readback_option);
    else if (reg_index == IDX_POWER_CONTROL)
      read_byte = power_control;
    else if (reg_index == IDX_PORT_B_WAKE_CONTROL)
      read_byte = {2'b00, port_b_wake_enable};
    else if (reg_index == IDX_PC_HIGH_BUFFER)
      read_byte = {constant_sink_enable, 1'b0, 3'b000,
                   program_counter_high_buffer};
    else
      read_hit = 1'b0;
  end

  // Read data is captured with pready so it stands in the answer cycle
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel & penable & ~pready)
    begin
      prdata  <= (pwrite || !read_hit || !addr_aligned) ? 32'h0000_0000
                                                         : {24'h00_0000, read_byte};
      pslverr <= ~read_hit | ~addr_aligned;
    end
    else
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // Timer load strobe into the counter module
  assign tz.load       = wr_en & (reg_index == IDX_TIMER_ZERO_VALUE);
  assign tz.load_value = wbyte;

  // Program counter; a software write to the low byte behaves as a computed jump
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      program_counter <= PROGRAM_COUNTER_RESET;
    else if (wr_en && reg_index == IDX_PROGRAM_COUNTER_LOW)
      program_counter <= {program_counter_high_buffer, wbyte};
    else if (instr_valid)
    begin
      case (instr_kind)
        instr_short_jump:
          program_counter <= {program_counter_high_buffer[2:1],
                              instr_target[8:0]};
        instr_short_call:
          program_counter <= {program_counter_high_buffer,
                              instr_target[7:0]};
        instr_long_jump,
        instr_long_call:
          program_counter <= instr_target;
        default:
          program_counter <= pc_plus_one;
      endcase
    end
  end

  // Return address push for calls
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stack_push      <= 1'b0;
      stack_push_addr <= 11'h000;
    end
    else
    begin
      stack_push <= instr_valid &&
                    (instr_kind == instr_short_call || instr_kind == instr_long_call);
      if (instr_valid)
        stack_push_addr <= pc_plus_one;
    end
  end

  // Status: hardware events override a software write in the same cycle
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      status_flags <= STATUS_RESET;
    else
    begin
      if (wr_en && reg_index == IDX_STATUS_FLAGS)
        status_flags <= wbyte;
      if (alu_valid && (alu_op == alu_add || alu_op == alu_sub))
      begin
        status_flags[STATUS_CARRY]      <= full_carry(alu_op, alu_a, alu_b);
        status_flags[STATUS_HALF_CARRY] <= half_carry(alu_op, alu_a, alu_b);
      end
      if (alu_valid && alu_op == alu_logic)
        status_flags[STATUS_ZERO] <= (alu_logic_result == 8'h00);
      if (instr_valid && instr_kind == instr_clear_watchdog)
      begin
        status_flags[STATUS_POWER_DOWN] <= 1'b1;
        status_flags[STATUS_WDT_EXPIRY] <= 1'b1;
      end
      if (instr_valid && instr_kind == instr_sleep)
      begin
        status_flags[STATUS_POWER_DOWN] <= 1'b0;
        status_flags[STATUS_WDT_EXPIRY] <= 1'b1;
      end
      if (watchdog_timeout)
        status_flags[STATUS_WDT_EXPIRY] <= 1'b0;
    end
  end

  // Pointer for indirect access; bank bits come from status
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      indirect_pointer <= INDIRECT_PTR_RESET;
    else if (wr_en && reg_index == IDX_INDIRECT_POINTER)
      indirect_pointer <= wbyte;
  end

  // Port output latches
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      first_port_latch  <= 8'h00;
      second_port_latch <= 8'h00;
    end
    else
    begin
      if (wr_en && reg_index == IDX_FIRST_PORT_DATA)
        first_port_latch <= wbyte;
      if (wr_en && reg_index == IDX_SECOND_PORT_DATA)
        second_port_latch <= wbyte;
    end
  end

  // Power control enables
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      power_control <= POWER_CONTROL_RESET;
    else if (wr_en && reg_index == IDX_POWER_CONTROL)
      power_control <= wbyte;
  end

  // Wake enables; upper two bits are not stored
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      port_b_wake_enable <= PORT_B_WAKE_RESET;
    else if (wr_en && reg_index == IDX_PORT_B_WAKE_CONTROL)
      port_b_wake_enable <= wbyte[5:0];
  end

  // High buffer, sink enable and boost stop; boost stop cannot be undone
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      program_counter_high_buffer <= PC_HIGH_BUF_RESET;
      constant_sink_enable        <= 1'b0;
      crystal_boost_stop          <= 1'b0;
    end
    else if (wr_en && reg_index == IDX_PC_HIGH_BUFFER)
    begin
      program_counter_high_buffer <= wbyte[2:0];
      constant_sink_enable        <= wbyte[PCHB_SINK_ENABLE];
      if (wbyte[PCHB_BOOST_STOP])
        crystal_boost_stop <= 1'b1;
    end
  end

endmodule : core_special_register_bank
`default_nettype wire

/* dv/core_sfr_monitor.sv */
// Checker for PC loading, return pushes and status flags
`timescale 1ns/1ps
`default_nettype none
module core_sfr_monitor
  import core_sfr_pkg::*;
(
  input wire logic        clk_sys,                     // Clock
  input wire logic        sys_rst,                     // Reset
  input wire logic        psel,                        // Bus select
  input wire logic        instr_valid,                 // Retire
  input wire instr_kind_t instr_kind,                  // Kind
  input wire logic [10:0] instr_target,                // Target
  input wire logic        alu_valid,                   // ALU strobe
  input wire alu_op_t     alu_op,                      // ALU op
  input wire logic [7:0]  alu_a,                       // Operand
  input wire logic [7:0]  alu_b,                       // Operand
  input wire logic [7:0]  alu_logic_result,            // Logic result
  input wire logic        watchdog_timeout,            // Timeout
  input wire logic [10:0] program_counter,             // PC
  input wire logic        stack_push,                  // Push
  input wire logic [10:0] stack_push_addr,             // Return address
  input wire logic [7:0]  status_flags,                // Status
  input wire logic [2:0]  program_counter_high_buffer  // High buffer
);
  wire [8:0]  sum9  = {1'b0, alu_a} + {1'b0, alu_b};
  wire [4:0]  sum5  = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
  // A set flag on subtract means no borrow was taken
  wire [1:0]  sub_cd = {alu_a[3:0] >= alu_b[3:0], alu_a >= alu_b};
  wire [1:0]  cd_exp = (alu_op == alu_add) ? {sum5[4], sum9[8]} : sub_cd;
  wire [10:0] sj_pc  = {program_counter_high_buffer[2:1], instr_target[8:0]};
  wire [10:0] sc_pc  = {program_counter_high_buffer, instr_target[7:0]};
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  property p_arith;
    alu_valid && alu_op inside {alu_add, alu_sub} |=> status_flags[1:0] == $past(cd_exp);
  endproperty
  a_arith: assert property (p_arith) else $error("Carry flags wrong");
  property p_zero;
    alu_valid && alu_op == alu_logic |=> status_flags[2] == ($past(alu_logic_result) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("Zero flag wrong");
  // Bus traffic is excluded since a write to the PC low byte wins
  property p_short_jump;
    instr_valid && instr_kind == instr_short_jump && !psel |=> program_counter == $past(sj_pc);
  endproperty
  a_short_jump: assert property (p_short_jump) else $error("Short jump PC wrong");
  property p_short_call;
    instr_valid && instr_kind == instr_short_call && !psel
      |=> program_counter == $past(sc_pc) && stack_push;
  endproperty
  a_short_call: assert property (p_short_call) else $error("Short call wrong");
  property p_long_jump;
    instr_valid && instr_kind == instr_long_jump && !psel
      |=> program_counter == $past(instr_target);
  endproperty
  a_long_jump: assert property (p_long_jump) else $error("Long jump PC wrong");
  property p_long_call;
    instr_valid && instr_kind == instr_long_call && !psel
      |=> stack_push && stack_push_addr == $past(program_counter) + 11'h001;
  endproperty
  a_long_call: assert property (p_long_call) else $error("Long call push wrong");
  property p_sleep;
    instr_valid && instr_kind == instr_sleep && !watchdog_timeout |=> status_flags[4:3] == 2'b10;
  endproperty
  a_sleep: assert property (p_sleep) else $error("Sleep flags wrong");
  property p_timeout;
    watchdog_timeout |=> !status_flags[STATUS_WDT_EXPIRY];
  endproperty
  a_timeout: assert property (p_timeout) else $error("Expiry flag not cleared");
endmodule : core_sfr_monitor

bind core_special_register_bank core_sfr_monitor mon (.*);
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the core special-function register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import core_sfr_pkg::*;
;
  logic        clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, er, wd;
  logic        instr_valid, alu_valid, watchdog_timeout, port_readback_option, stack_push;
  logic        timer_zero_mode_select, timer_zero_low_osc_select, instruction_clock;
  logic        external_count_input, low_osc_clock, crystal_boost_stop, constant_sink_enable;
  logic        pd, to, c, dc, z;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  instr_kind_t instr_kind;
  alu_op_t     alu_op;
  logic [10:0] instr_target, program_counter, stack_push_addr, pc, ret, tg;
  logic [7:0]  alu_a, alu_b, alu_logic_result, first_port_pins, first_port_is_input;
  logic [7:0]  status_flags, indirect_pointer, first_port_latch, second_port_latch;
  logic [7:0]  power_control, v, w, p, m, ex;
  logic [5:0]  second_port_pins, second_port_is_input, port_b_wake_enable;
  logic [2:0]  program_counter_high_buffer, hb;
  int          bad_count, comparisons, k, n;
  logic [9:0]  ri [7] = '{IDX_TIMER_ZERO_VALUE, IDX_PROGRAM_COUNTER_LOW, IDX_STATUS_FLAGS,
    IDX_INDIRECT_POINTER, IDX_POWER_CONTROL, IDX_PORT_B_WAKE_CONTROL, IDX_PC_HIGH_BUFFER};
  logic [7:0]  rv [7] = '{8'h00, 8'h00, 8'h18, 8'h00, 8'h88, 8'h3f, 8'h00};

  core_special_register_bank dut (.*);

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  // One bus transfer; read data and error are taken at the ready edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int t;
    @(posedge clk_sys);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, 24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    t = 0;
    do @(posedge clk_sys); while (pready !== 1'b1 && ++t < 20);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    if (t >= 20)
    begin
      bad_count++;
      $display("[FAIL] %0t no ready", $time);
      end_sim();
    end
  endtask : apb

  task automatic rchk(input logic [9:0] i, input logic [31:0] e);
    apb(1'b0, {i, 2'b00}, 8'h00);
    chk(rd, e);
  endtask : rchk

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, instr_valid, instr_target, alu_valid} = '0;
    {alu_a, alu_b, alu_logic_result, watchdog_timeout, first_port_pins, second_port_pins} = '0;
    {first_port_is_input, second_port_is_input, port_readback_option, instruction_clock} = '0;
    {timer_zero_mode_select, timer_zero_low_osc_select, external_count_input} = '0;
    {low_osc_clock, bad_count, comparisons, pc, c, dc, z} = '0;
    instr_kind = instr_step;
    alu_op = alu_none;
    {pd, to} = 2'b11;
    sys_rst = 1'b1;
    k = $urandom(32'h9137);
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < 7; i++)
      rchk(ri[i], {24'h0, rv[i]});
    v = $urandom | 8'h40;
    hb = v[2:0];
    apb(1'b1, {IDX_PC_HIGH_BUFFER, 2'b00}, v);
    rchk(IDX_PC_HIGH_BUFFER, {24'h0, v[7], 4'h0, v[2:0]});
    chk({crystal_boost_stop, constant_sink_enable, program_counter_high_buffer}, {1'b1, v[7], v[2:0]});
    for (int i = 0; i < 60; i++)
    begin
      k = $urandom % 7;
      n = $urandom % 4;
      {v, w, tg} = {8'($urandom), 8'($urandom), 11'($urandom)};
      p = ($urandom % 2) ? 8'h00 : 8'($urandom);
      wd = ($urandom % 5) == 0;
      instr_kind <= instr_kind_t'(k);
      alu_op <= alu_op_t'(n);
      {instr_valid, instr_target, watchdog_timeout, alu_valid} <= {1'b1, tg, wd, 1'b1};
      {alu_a, alu_b, alu_logic_result} <= {v, w, p};
      @(posedge clk_sys);
      {instr_valid, alu_valid, watchdog_timeout} <= 3'b000;
      ret = pc + 11'h001;
      case (k)
        1: pc = {hb[2:1], tg[8:0]};
        2: pc = {hb, tg[7:0]};
        3, 4: pc = tg;
        default: pc = ret;
      endcase
      if (k == 5) {pd, to} = 2'b01;
      if (k == 6) {pd, to} = 2'b11;
      if (wd) to = 1'b0;
      if (n == 1) {dc, c} = {(v[3:0] + w[3:0]) > 15, (v + w) > 255};
      if (n == 2) {dc, c} = {v[3:0] >= w[3:0], v >= w};
      if (n == 3) z = (p == 8'h00);
      #1;
      chk(program_counter, pc);
      chk(stack_push, k == 2 || k == 4);
      if (k == 2 || k == 4) chk(stack_push_addr, ret);
      chk(status_flags[4:0], {to, pd, z, dc, c});
      @(posedge clk_sys);
    end
    rchk(IDX_PROGRAM_COUNTER_LOW, {24'h0, pc[7:0]});
    v = $urandom;
    apb(1'b1, {IDX_PROGRAM_COUNTER_LOW, 2'b00}, v);
    #1;
    chk(program_counter, {hb, v});
    for (int i = 3; i < 6; i++)
    begin
      v = $urandom;
      apb(1'b1, {ri[i], 2'b00}, v);
      rchk(ri[i], {24'h0, v & (i == 5 ? 8'h3f : 8'hff)});
      if (i < 5) chk(i == 3 ? indirect_pointer : power_control, v);
    end
    chk(port_b_wake_enable, v[5:0]);
    for (int b = 0; b < 4; b++)
    begin
      v = {b[1:0], 6'($urandom)};
      apb(1'b1, {IDX_STATUS_FLAGS, 2'b00}, v);
      #1;
      chk(status_flags & 8'he7, v & 8'he7);
    end
    rchk(10'h007, 32'h0);
    chk(er, 1'b1);
    // Each source is pulsed with a low gap so the synchronised edge is seen
    for (int s = 0; s < 3; s++)
    begin
      {timer_zero_mode_select, timer_zero_low_osc_select} <= {s != 0, s == 2};
      v = $urandom;
      n = 1 + $urandom % 5;
      apb(1'b1, {IDX_TIMER_ZERO_VALUE, 2'b00}, v);
      repeat (n)
      begin
        @(posedge clk_sys);
        {low_osc_clock, external_count_input, instruction_clock} <= 3'(1 << s);
        @(posedge clk_sys);
        {low_osc_clock, external_count_input, instruction_clock} <= 3'b000;
      end
      repeat (5) @(posedge clk_sys);
      rchk(IDX_TIMER_ZERO_VALUE, {24'h0, 8'(v + n)});
    end
    for (int o = 0; o < 2; o++)
    begin
      {v, p, m} = {8'($urandom), 8'($urandom), 8'($urandom)};
      {port_readback_option, first_port_pins, second_port_pins} <= {o[0], p, p[5:0]};
      {first_port_is_input, second_port_is_input} <= {m, m[5:0]};
      apb(1'b1, {IDX_FIRST_PORT_DATA, 2'b00}, v);
      apb(1'b1, {IDX_SECOND_PORT_DATA, 2'b00}, v);
      repeat (3) @(posedge clk_sys);
      ex = (m & p) | (~m & (o == 1 ? v : p));
      rchk(IDX_FIRST_PORT_DATA, {24'h0, ex});
      rchk(IDX_SECOND_PORT_DATA, {24'h0, v[7:6], ex[5:0]});
      chk({first_port_latch, second_port_latch}, {v, v});
    end
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
